//--- rtl/ras_pkg.sv
// Package for the repeater authentication sequencer: register map,
// field positions, reset values and shared types.
// Assumes a 32-bit APB register bus and a single 250 MHz clock.
package ras_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_LINK_CTRL = 8'h04;
  localparam logic [7:0] OFF_CONFIG    = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFF_KEY_DATA  = 8'h14;
  localparam logic [7:0] OFF_TOPOLOGY  = 8'h18;
  localparam logic [7:0] OFF_VERIFY    = 8'h1C;
  localparam logic [7:0] OFF_TX_KEY    = 8'h20;
  localparam logic [7:0] OFF_KEY_COUNT = 8'h24;
  localparam logic [7:0] OFF_SECRET    = 8'h28;

  // Link control fields (offset 0x04)
  localparam int unsigned BIT_FWD_EN = 0;
  localparam int unsigned BIT_REV_EN = 1;
  localparam logic [1:0]  LINK_CTRL_RST = 2'h3;

  // Configuration fields
  localparam int unsigned BIT_PIN0_OPT = 0;
  localparam int unsigned BIT_PIN1_OPT = 1;
  localparam int unsigned BIT_ENC_EN   = 2;

  // Status / mask fields, same layout in bits 0-3; bits 8 and 9 are status only
  localparam int unsigned BIT_AUTH_BEGUN = 0;
  localparam int unsigned BIT_HASH_DONE  = 1;
  localparam int unsigned BIT_CONTENTION = 2;
  localparam int unsigned BIT_NEW_DEV    = 3;
  localparam int unsigned STAT_W         = 4;
  localparam int unsigned BIT_HASH_BUSY  = 8;
  localparam int unsigned BIT_ENC_LIVE   = 9;

  localparam logic [31:0] HASH_SEED = 32'h811C9DC5;
  localparam logic [31:0] HASH_MULT = 32'h01000193;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ras_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ras_apb_rsp_t;

  typedef struct packed {
    logic pin0_follow_option;
    logic pin1_follow_option;
    logic encrypt_request;
  } ras_config_t;

endpackage

//--- rtl/ras_hash_core.sv
// Sequential list hash: mixes the stored key list, the topology word
// and the internal secret into one verification value.
// Assumes the list memory is read combinationally through key_idx_o.
`timescale 1ns/10ps
module ras_hash_core #(
  parameter int unsigned KEY_W   = 40,
  parameter int unsigned IDX_W   = 7
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             start_i,
  input  wire logic [IDX_W-1:0] key_count_i,
  input  wire logic [KEY_W-1:0] key_data_i,
  input  wire logic [31:0]      topology_word_i,
  input  wire logic [63:0]      internal_secret_i,
  output logic      [IDX_W-1:0] key_idx_o,
  output logic                  busy_o,
  output logic                  done_o,
  output logic      [31:0]      value_o
);

  typedef enum {RAS_H_IDLE, RAS_H_KEYS, RAS_H_TOPO, RAS_H_SEC_LO,
                RAS_H_SEC_HI} ras_hstate_t;

  ras_hstate_t      state;
  logic [31:0]      acc;
  logic [IDX_W-1:0] idx;

  function automatic logic [31:0] mix(input logic [31:0] a,
                                      input logic [31:0] d);
    logic [63:0] p;
    p = 64'((a ^ d)) * 64'(ras_pkg::HASH_MULT);
    mix = p[31:0] ^ {p[15:0], p[31:16]};
  endfunction

  assign key_idx_o = idx;
  assign busy_o    = (state != RAS_H_IDLE);

  always_ff @(posedge core_clk_i) begin
    done_o <= 1'b0;
    if (reset_i) begin
      state   <= RAS_H_IDLE;
      acc     <= '0;
      idx     <= '0;
      value_o <= '0;
    end else begin
      case (state)
        RAS_H_IDLE: begin
          if (start_i) begin
            acc   <= ras_pkg::HASH_SEED;
            idx   <= '0;
            state <= (key_count_i == '0) ? RAS_H_TOPO : RAS_H_KEYS;
          end
        end
        RAS_H_KEYS: begin
          // Keys are folded low 32 bits first, then the upper part
          acc <= mix(mix(acc, key_data_i[31:0]),
                     32'(key_data_i[KEY_W-1:32]));
          idx <= idx + 1'b1;
          if (idx + 1'b1 == key_count_i) state <= RAS_H_TOPO;
        end
        RAS_H_TOPO: begin
          acc   <= mix(acc, topology_word_i);
          state <= RAS_H_SEC_LO;
        end
        RAS_H_SEC_LO: begin
          acc   <= mix(acc, internal_secret_i[31:0]);
          state <= RAS_H_SEC_HI;
        end
        RAS_H_SEC_HI: begin
          value_o <= mix(acc, internal_secret_i[63:32]);
          done_o  <= 1'b1;
          state   <= RAS_H_IDLE;
        end
        default: state <= RAS_H_IDLE;
      endcase
    end
  end

endmodule

//--- rtl/ras_sequencer.sv
// Repeater authentication sequencer: APB register file, list hash
// trigger, auth-begun flag, pin mirroring and control-channel gating.
// Assumes a single 250 MHz clock, synchronous reset and APB master.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module ras_sequencer #(
  parameter int unsigned KEY_W    = 40,
  parameter int unsigned MAX_KEYS = 127,
  parameter int unsigned IDX_W    = 7
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire ras_pkg::ras_apb_req_t apb_req_i,
  output ras_pkg::ras_apb_rsp_t     apb_rsp_o,
  input  wire logic                 vsync_i,
  input  wire logic                 fwd_req_i,
  input  wire logic                 rev_req_i,
  input  wire logic                 contention_i,
  output logic                      fwd_pass_o,
  output logic                      rev_pass_o,
  output logic                      ack_allow_o,
  output logic                      encrypt_active_o,
  output logic                      general_pin_0_o,
  output logic                      general_pin_0_oe_o,
  output logic                      general_pin_1_o,
  output logic                      general_pin_1_oe_o,
  output logic                      irq_o
);

  logic [KEY_W-1:0]  key_mem [MAX_KEYS];
  logic [IDX_W-1:0]  key_wr_idx;
  logic [IDX_W-1:0]  hash_idx;
  logic [31:0]       topology_word;
  logic [31:0]       verify_value;
  logic [KEY_W-1:0]  transmitter_public_key;
  logic [63:0]       internal_secret;
  logic [1:0]        link_ctrl;
  ras_pkg::ras_config_t cfg;
  logic [ras_pkg::STAT_W-1:0] status;
  logic [ras_pkg::STAT_W-1:0] irq_mask;
  logic [ras_pkg::STAT_W-1:0] next_status;
  logic              hash_start;
  logic              hash_busy;
  logic              hash_done;
  logic              encrypt_active;
  logic [2:0]        vs_sync;
  logic              vs_stable;
  logic              new_dev_in;

  logic              wr_en;
  logic              rd_en;
  logic [7:0]        addr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              addr_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Single-cycle access phase: pready is always high
  assign addr    = apb_req_i.paddr;
  assign wdata   = apb_req_i.pwdata;
  assign wr_en   = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign rd_en   = apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rdata   = '0;
    case (addr)
      ras_pkg::OFF_LINK_CTRL: rdata = 32'(link_ctrl);
      ras_pkg::OFF_CONFIG:    rdata = 32'({cfg.encrypt_request,
                                           cfg.pin1_follow_option,
                                           cfg.pin0_follow_option});
      ras_pkg::OFF_STATUS: begin
        rdata = 32'(status);
        rdata[ras_pkg::BIT_HASH_BUSY] = hash_busy;
        rdata[ras_pkg::BIT_ENC_LIVE]  = encrypt_active;
      end
      ras_pkg::OFF_IRQ_MASK:  rdata = 32'(irq_mask);
      ras_pkg::OFF_KEY_DATA:  rdata = '0;
      ras_pkg::OFF_TOPOLOGY:  rdata = topology_word;
      ras_pkg::OFF_VERIFY:    rdata = verify_value;
      ras_pkg::OFF_TX_KEY:    rdata = transmitter_public_key[31:0];
      ras_pkg::OFF_KEY_COUNT: rdata = 32'(key_wr_idx);
      ras_pkg::OFF_SECRET:    rdata = '0;
      default:                addr_ok = 1'b0;
    endcase
  end

  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = (wr_en | rd_en) & ~addr_ok;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      apb_rsp_o.prdata <= '0;
    end else if (apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite) begin
      apb_rsp_o.prdata <= rdata;
    end
  end

  // Control registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      link_ctrl <= ras_pkg::LINK_CTRL_RST;
      cfg       <= '0;
      irq_mask  <= '0;
    end else if (wr_en) begin
      if (hit(addr, ras_pkg::OFF_LINK_CTRL))
        link_ctrl <= wdata[1:0];
      if (hit(addr, ras_pkg::OFF_CONFIG)) begin
        cfg.pin0_follow_option <= wdata[ras_pkg::BIT_PIN0_OPT];
        cfg.pin1_follow_option <= wdata[ras_pkg::BIT_PIN1_OPT];
        cfg.encrypt_request    <= wdata[ras_pkg::BIT_ENC_EN];
      end
      if (hit(addr, ras_pkg::OFF_IRQ_MASK))
        irq_mask <= wdata[ras_pkg::STAT_W-1:0];
    end
  end

  // Key list, topology word, transmitter key and secret
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      key_wr_idx             <= '0;
      topology_word          <= '0;
      transmitter_public_key <= '0;
      internal_secret        <= '0;
    end else if (wr_en) begin
      if (hit(addr, ras_pkg::OFF_KEY_DATA) &&
          key_wr_idx < IDX_W'(MAX_KEYS)) begin
        key_mem[key_wr_idx] <= KEY_W'(wdata);
        key_wr_idx          <= key_wr_idx + 1'b1;
      end
      // A list restarts when the key count register is written
      if (hit(addr, ras_pkg::OFF_KEY_COUNT))
        key_wr_idx <= '0;
      if (hit(addr, ras_pkg::OFF_TOPOLOGY))
        topology_word <= wdata;
      if (hit(addr, ras_pkg::OFF_TX_KEY))
        transmitter_public_key <= KEY_W'(wdata);
      if (hit(addr, ras_pkg::OFF_SECRET))
        internal_secret <= {internal_secret[31:0], wdata};
    end
  end

  // Topology write launches the hash; ignored while one is running
  assign hash_start = wr_en & hit(addr, ras_pkg::OFF_TOPOLOGY)
                      & ~hash_busy;

  ras_hash_core #(
    .KEY_W (KEY_W),
    .IDX_W (IDX_W)
  ) u_hash (
    .core_clk_i        (core_clk_i),
    .reset_i           (reset_i),
    .start_i           (hash_start),
    .key_count_i       (key_wr_idx),
    .key_data_i        (key_mem[hash_idx]),
    .topology_word_i   (topology_word),
    .internal_secret_i (internal_secret),
    .key_idx_o         (hash_idx),
    .busy_o            (hash_busy),
    .done_o            (hash_done),
    .value_o           (verify_value)
  );

  // Vertical sync from a pin: three stages, change once last two agree
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      vs_sync   <= '0;
      vs_stable <= 1'b0;
    end else begin
      vs_sync <= {vs_sync[1:0], vsync_i};
      if (vs_sync[1] == vs_sync[2])
        vs_stable <= vs_sync[2];
    end
  end

  // Encryption state changes only on a falling vertical sync
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      encrypt_active <= 1'b0;
    end else if (vs_stable && vs_sync[1] == vs_sync[2] && !vs_sync[2]) begin
      encrypt_active <= cfg.encrypt_request;
    end
  end
  assign encrypt_active_o = encrypt_active;

  // Sticky status: hardware set wins over write-one-to-clear
  assign new_dev_in = wr_en & hit(addr, ras_pkg::OFF_STATUS)
                      & wdata[ras_pkg::STAT_W + ras_pkg::BIT_NEW_DEV];
  always_comb begin
    next_status = status;
    if (wr_en && hit(addr, ras_pkg::OFF_STATUS))
      next_status = status & ~wdata[ras_pkg::STAT_W-1:0];
    if (wr_en && hit(addr, ras_pkg::OFF_TX_KEY))
      next_status[ras_pkg::BIT_AUTH_BEGUN] = 1'b1;
    if (hash_done)
      next_status[ras_pkg::BIT_HASH_DONE] = 1'b1;
    if (contention_i)
      next_status[ras_pkg::BIT_CONTENTION] = 1'b1;
    if (new_dev_in)
      next_status[ras_pkg::BIT_NEW_DEV] = 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status <= '0;
      irq_o  <= 1'b0;
    end else begin
      status <= next_status;
      irq_o  <= |(next_status & irq_mask);
    end
  end

  // Control channel gating; contention suppresses acknowledge
  assign fwd_pass_o  = fwd_req_i & link_ctrl[ras_pkg::BIT_FWD_EN];
  assign rev_pass_o  = rev_req_i & link_ctrl[ras_pkg::BIT_REV_EN];
  assign ack_allow_o = ~contention_i;

  // Pins are driven only while their follow option is set
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      general_pin_0_o    <= 1'b0;
      general_pin_0_oe_o <= 1'b0;
      general_pin_1_o    <= 1'b0;
      general_pin_1_oe_o <= 1'b0;
    end else begin
      general_pin_0_oe_o <= cfg.pin0_follow_option;
      general_pin_0_o    <= cfg.pin0_follow_option
                            & cfg.encrypt_request;
      general_pin_1_oe_o <= cfg.pin1_follow_option;
      general_pin_1_o    <= cfg.pin1_follow_option
                            & next_status[ras_pkg::BIT_AUTH_BEGUN];
    end
  end

endmodule

//--- test/ras_seq_monitor.sv
// Port-level checker for the repeater authentication sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ras_seq_monitor (
  input wire logic                  core_clk_i,
  input wire logic                  reset_i,
  input wire ras_pkg::ras_apb_req_t apb_req_i,
  input wire ras_pkg::ras_apb_rsp_t apb_rsp_o,
  input wire logic                  vsync_i,
  input wire logic                  fwd_req_i,
  input wire logic                  rev_req_i,
  input wire logic                  contention_i,
  input wire logic                  fwd_pass_o,
  input wire logic                  rev_pass_o,
  input wire logic                  ack_allow_o,
  input wire logic                  encrypt_active_o,
  input wire logic                  general_pin_0_o,
  input wire logic                  general_pin_1_o
);
  logic [1:0] link_sh;
  logic [2:0] cfg_sh;
  logic [3:0] cfg_age;
  logic [3:0] vs_age;
  logic       wr_acc;
  logic       rd_setup;
  logic       mapped;
  assign wr_acc = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign rd_setup = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;
  assign mapped = apb_req_i.paddr >= 8'h04 && apb_req_i.paddr <= 8'h28 &&
                  apb_req_i.paddr[1:0] == 2'h0;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) link_sh <= ras_pkg::LINK_CTRL_RST;
    else if (wr_acc && apb_req_i.paddr == ras_pkg::OFF_LINK_CTRL)
      link_sh <= apb_req_i.pwdata[1:0];
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) cfg_sh <= 3'h0;
    else if (wr_acc && apb_req_i.paddr == ras_pkg::OFF_CONFIG)
      cfg_sh <= apb_req_i.pwdata[2:0];
  end
  // Pin outputs are registered, so a fresh config needs a few cycles
  always_ff @(posedge core_clk_i) begin
    if (reset_i || (wr_acc && apb_req_i.paddr == ras_pkg::OFF_CONFIG))
      cfg_age <= 4'h0;
    else if (cfg_age != 4'hF) cfg_age <= cfg_age + 4'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) vs_age <= 4'hF;
    else if ($fell(vsync_i)) vs_age <= 4'h0;
    else if (vs_age != 4'hF) vs_age <= vs_age + 4'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_key_write;
    wr_acc && apb_req_i.paddr == ras_pkg::OFF_TX_KEY && cfg_sh[1];
  endsequence
  a_fwd_gate: assert property (fwd_pass_o == (fwd_req_i && link_sh[0]))
    else $error("forward pass does not follow request and enable");
  a_rev_gate: assert property (rev_pass_o == (rev_req_i && link_sh[1]))
    else $error("reverse pass does not follow request and enable");
  a_ack_block: assert property (contention_i |-> !ack_allow_o)
    else $error("acknowledge allowed during contention");
  a_ack_free: assert property (!contention_i |-> ack_allow_o)
    else $error("acknowledge withheld without contention");
  a_ready_high: assert property (apb_req_i.psel |-> apb_rsp_o.pready)
    else $error("pready low during a transfer");
  a_slverr_bad: assert property
    (apb_req_i.psel && apb_req_i.penable && !mapped |-> apb_rsp_o.pslverr)
    else $error("unmapped access not refused");
  a_slverr_good: assert property
    (apb_req_i.psel && apb_req_i.penable && mapped |-> !apb_rsp_o.pslverr)
    else $error("mapped access refused");
  a_pin1_raise: assert property (s_key_write |-> ##[1:2] general_pin_1_o)
    else $error("pin 1 not raised after key write");
  a_pin0_follow: assert property
    (cfg_age >= 4'h3 && cfg_sh[0] |-> general_pin_0_o == cfg_sh[2])
    else $error("pin 0 does not follow encryption enable");
  a_enc_at_sync: assert property
    ($changed(encrypt_active_o) |-> vs_age <= 4'h8)
    else $error("encryption changed away from a vsync fall");
  a_rdata_hold: assert property
    ($changed(apb_rsp_o.prdata) |-> $past(rd_setup))
    else $error("read data changed outside a read setup");
endmodule
bind ras_sequencer ras_seq_monitor u_mon (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .vsync_i(vsync_i), .fwd_req_i(fwd_req_i),
  .rev_req_i(rev_req_i), .contention_i(contention_i),
  .fwd_pass_o(fwd_pass_o), .rev_pass_o(rev_pass_o),
  .ack_allow_o(ack_allow_o), .encrypt_active_o(encrypt_active_o),
  .general_pin_0_o(general_pin_0_o), .general_pin_1_o(general_pin_1_o));

//--- test/ras_link_peer.sv
// Link-side peer model: vsync frames and cross-link channel traffic.
// Assumes the bench clock; quiet_i holds the channel idle.
`timescale 1ns/10ps
module ras_link_peer (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic quiet_i,
  output logic      vsync_o,
  output logic      fwd_req_o,
  output logic      rev_req_o,
  output logic      contention_o
);
  logic [5:0] frame_cnt;
  initial begin
    frame_cnt = 6'h00;
    fwd_req_o = 1'b0;
    rev_req_o = 1'b0;
    contention_o = 1'b0;
  end
  // Short frames keep the run brief: 20 cycles high, 20 low
  always @(posedge core_clk_i) begin
    if (reset_i || frame_cnt == 6'h27) frame_cnt <= 6'h00;
    else frame_cnt <= frame_cnt + 6'h01;
  end
  assign vsync_o = frame_cnt < 6'h14;
  // No higher protocol: both sides may talk at once
  always @(posedge core_clk_i) begin
    fwd_req_o <= !quiet_i && $urandom_range(1);
    rev_req_o <= !quiet_i && $urandom_range(1);
    contention_o <= !quiet_i && $urandom_range(3) == 0;
  end
endmodule

//--- test/test_repeater_auth_sequencer.sv
// Self-checking bench for the repeater authentication sequencer.
// Assumes the link peer model and the bound port checker.
`timescale 1ns/10ps
module test_repeater_auth_sequencer;
  logic                  clk = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  quiet = 1'b0;
  ras_pkg::ras_apb_req_t req = '0;
  ras_pkg::ras_apb_rsp_t rsp;
  logic                  vs, fr, rr, ct, fp, rp, ack, enc, p0, p1, irq, err;
  logic [31:0]           rd;
  logic [1:0]            link_m;
  int                    miscompares = 0;
  int                    total_checks = 0;
  int                    nk;
  logic [31:0]           kq[$];
  logic [31:0]           topo, sec_hi, sec_lo;
  // Reference mixing step of the list hash, built from the package multiplier
  function automatic logic [31:0] mix(input logic [31:0] a,
                                      input logic [31:0] d);
    logic [63:0] p;
    p = 64'(a ^ d) * 64'(ras_pkg::HASH_MULT);
    return p[31:0] ^ {p[15:0], p[31:16]};
  endfunction
  // Keys are 32-bit words zero-extended, so each upper part folds as 0
  function automatic logic [31:0] model_hash();
    logic [31:0] acc;
    acc = ras_pkg::HASH_SEED;
    foreach (kq[i]) acc = mix(mix(acc, kq[i]), 32'h0);
    acc = mix(acc, topo);
    acc = mix(acc, sec_lo);
    return mix(acc, sec_hi);
  endfunction
  initial forever #2 clk = ~clk;
  ras_link_peer u_peer (.core_clk_i(clk), .reset_i(reset_i),
    .quiet_i(quiet), .vsync_o(vs), .fwd_req_o(fr), .rev_req_o(rr),
    .contention_o(ct));
  ras_sequencer DUT (.core_clk_i(clk), .reset_i(reset_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .vsync_i(vs), .fwd_req_i(fr), .rev_req_i(rr),
    .contention_i(ct), .fwd_pass_o(fp), .rev_pass_o(rp), .ack_allow_o(ack),
    .encrypt_active_o(enc), .general_pin_0_o(p0), .general_pin_0_oe_o(),
    .general_pin_1_o(p1), .general_pin_1_oe_o(), .irq_o(irq));
  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      report_and_stop();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd & m, exp);
  endtask
  task automatic wait_fall();
    int n;
    for (n = 0; n < 200 && vs !== 1'b1; n++) @(negedge clk);
    if (n == 200) begin
      miscompares++;
      report_and_stop();
    end
    for (n = 0; n < 200 && vs !== 1'b0; n++) @(negedge clk);
    if (n == 200) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial begin
    void'($urandom(91));
    repeat (2) @(posedge clk);
    reset_i <= 1'b0;
    rdchk(ras_pkg::OFF_LINK_CTRL, 32'h3, 32'h3);
    rdchk(ras_pkg::OFF_CONFIG, 32'h7, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk_bit(err, 1'b1);
    for (int v = 0; v < 4; v++) begin
      link_m = v[1:0];
      apb(1'b1, ras_pkg::OFF_LINK_CTRL, {30'h0, link_m});
      repeat (20) begin
        @(negedge clk);
        chk_bit(fp, fr & link_m[0]);
        chk_bit(rp, rr & link_m[1]);
        chk_bit(ack, !ct);
      end
    end
    quiet <= 1'b1;
    rdchk(ras_pkg::OFF_STATUS, 32'h4, 32'h4);
    apb(1'b1, ras_pkg::OFF_STATUS, 32'hF);
    apb(1'b1, ras_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, ras_pkg::OFF_CONFIG, 32'h2);
    apb(1'b1, ras_pkg::OFF_TX_KEY, $urandom);
    repeat (2) @(negedge clk);
    chk_bit(p1, 1'b1);
    rdchk(ras_pkg::OFF_STATUS, 32'hF, 32'h1);
    chk_bit(irq, 1'b0);
    apb(1'b1, ras_pkg::OFF_IRQ_MASK, 32'hF);
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b1);
    apb(1'b1, ras_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, ras_pkg::OFF_STATUS, 32'h1);
    rdchk(ras_pkg::OFF_STATUS, 32'hF, 32'h0);
    chk_bit(p1, 1'b0);
    chk_bit(irq, 1'b0);
    apb(1'b1, ras_pkg::OFF_STATUS, 32'h80);
    rdchk(ras_pkg::OFF_STATUS, 32'hF, 32'h8);
    apb(1'b1, ras_pkg::OFF_STATUS, 32'h8);
    sec_hi = $urandom;
    sec_lo = $urandom;
    apb(1'b1, ras_pkg::OFF_SECRET, sec_hi);
    apb(1'b1, ras_pkg::OFF_SECRET, sec_lo);
    apb(1'b1, ras_pkg::OFF_KEY_COUNT, 32'h0);
    nk = 3 + $urandom_range(4);
    repeat (nk) begin
      kq.push_back($urandom);
      apb(1'b1, ras_pkg::OFF_KEY_DATA, kq[$]);
    end
    rdchk(ras_pkg::OFF_KEY_COUNT, 32'h7F, nk);
    topo = $urandom;
    apb(1'b1, ras_pkg::OFF_TOPOLOGY, topo);
    rdchk(ras_pkg::OFF_STATUS, 32'h102, 32'h100);
    for (int i = 0; i < 100 && rd[1] !== 1'b1; i++)
      apb(1'b0, ras_pkg::OFF_STATUS, 32'h0);
    chk_bit(rd[1], 1'b1);
    rdchk(ras_pkg::OFF_VERIFY, 32'hFFFFFFFF, model_hash());
    apb(1'b1, ras_pkg::OFF_STATUS, 32'h2);
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, ras_pkg::OFF_CONFIG, {29'h0, e[0], 2'h1});
      repeat (3) @(negedge clk);
      chk_bit(p0, e[0]);
      wait_fall();
      chk_bit(enc, !e[0]);
      repeat (8) @(negedge clk);
      chk_bit(enc, e[0]);
    end
    report_and_stop();
  end
endmodule
